// [common/arut_pkg.sv]
// Constants, types and register map of the auto-reload up/down timer
// Function
// [R1] Mode register resets to interval, up, slowest
// [R2] Mode bit selects interval or auto-reload
// [R3] Software direction bit: 0 up, 1 down
// [R4] Direction pin steers count when source set
// [R5] Mode bits 4 and 3 read one
// [R6] Clock field codes 0-6 pick prescaled clocks
// [R7] Code 111 counts selected external event edges
// [R8] Software routes event pin before code 111
// [R9] Counter readable anytime, never directly written
// [R10] Overflow or underflow sets interrupt flag
// [R11] Shared address: read counter, write reload
// [R12] Counter clears to zero on reset
// [R13] Reload write also loads the counter
// [R14] Auto-reload mode reloads counter on wrap
// [R15] Reload register: write-only, resets to zero
// [R16] Interval mode wraps to zero or ones
// [R17] Interrupt output needs flag and enable
// [R18] Clock-stop bit 1 low halts timer
// [R19] Pins synchronised; one advance per edge
package arut_pkg;

    // Avalon byte address width; index times four is the byte address
    localparam int ADDR_W = 18;
    localparam int DATA_W = 32;

    // Register indices as printed; irq register placed in a free slot
    localparam logic [15:0] MODE_IDX = 16'hffb4;
    localparam logic [15:0] COUNT_IDX = 16'hffb5;
    localparam logic [15:0] IRQ_IDX = 16'hffb6;
    localparam logic [15:0] STOP_IDX = 16'hfffa;

    // Reset values
    localparam logic [7:0] MODE_RESET = 8'h18;
    localparam logic [7:0] COUNT_RESET = 8'h00;
    localparam logic [7:0] RELOAD_RESET = 8'h00;
    localparam logic [7:0] STOP_RESET = 8'hff;

    // Mode register field positions
    localparam int MODE_RELOAD_BIT = 7;
    localparam int MODE_DSRC_BIT = 6;
    localparam int MODE_SWDIR_BIT = 5;
    localparam int MODE_RSV_HI_BIT = 4;
    localparam int MODE_RSV_LO_BIT = 3;
    localparam int MODE_CLK_MSB = 2;
    localparam int MODE_CLK_LSB = 0;

    // Other field positions
    localparam int STOP_TIMER_BIT = 1;
    localparam int IRQ_FLAG_BIT = 0;
    localparam int IRQ_EN_BIT = 1;

    // Count limits
    localparam logic [7:0] COUNT_MAX = 8'hff;
    localparam logic [7:0] COUNT_MIN = 8'h00;

    // Clock select codes
    localparam logic [2:0] CLK_SUBCLK = 3'h6;
    localparam logic [2:0] CLK_EVENT = 3'h7;

    // Prescaler: divide-by-2^n tap widths for codes 0..5
    localparam int PRESC_W = 13;
    localparam int NUM_TAPS = 6;
    localparam int TAP_BITS [NUM_TAPS] = '{13, 11, 9, 6, 4, 2};

    // Decoded mode register contents
    typedef struct packed {
        logic reload_mode_select;
        logic direction_source_select;
        logic software_direction;
        logic [2:0] clk_sel;
    } arut_mode_t;

    // Bus answer phase
    typedef enum logic [1:0] {
        PH_IDLE = 2'b01,
        PH_ANSWER = 2'b10
    } arut_phase_t;

    // Whole state of the timer core
    typedef struct packed {
        arut_phase_t phase;
        arut_mode_t mode;
        logic [7:0] count_value;
        logic [7:0] reload_value;
        logic [7:0] module_clock_stop;
        logic timer_irq_flag;
        logic timer_irq_enable;
        logic [7:0] rdata;
    } arut_core_t;

    // State of one pin synchroniser
    typedef struct packed {
        logic meta;
        logic stable;
        logic prev;
    } arut_sync_t;

endpackage : arut_pkg

// [dv/arut_timer_asserts.sv]
// Bus and interrupt assertions for the auto-reload timer
`timescale 1ns/1ns
module arut_timer_asserts
(
    input wire logic i_core_clk,
    input wire logic i_arst_n,
    input wire logic [arut_pkg::ADDR_W-1:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [arut_pkg::DATA_W-1:0] i_avs_writedata,
    input wire logic [3:0] i_avs_byteenable,
    input wire logic [arut_pkg::DATA_W-1:0] o_avs_readdata,
    input wire logic o_avs_waitrequest,
    input wire logic o_irq
);
    // Byte address is the register index times four
    localparam logic [17:0] A_MODE = {arut_pkg::MODE_IDX, 2'b00};
    localparam logic [17:0] A_HOLE = 18'h3fedc;
    logic [7:0] mode_shadow_reg;
    logic req;
    logic take;

    // Request and completed transfer
    assign req = i_avs_read | i_avs_write;
    assign take = req & ~o_avs_waitrequest;

    default clocking dc @(posedge i_core_clk);
    endclocking
    default disable iff (!i_arst_n);

    // Expected mode readback; reserved bits can never be cleared
    always_ff @(posedge i_core_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
            mode_shadow_reg <= 8'h18;
        else if (take && i_avs_write && i_avs_byteenable[0]
            && i_avs_address == A_MODE)
            mode_shadow_reg <= i_avs_writedata[7:0] | 8'h18;
    end

    wait_first_a: assert property (
        $rose(req) |-> o_avs_waitrequest)
        else $error("answer came in the request cycle");
    wait_once_a: assert property (
        o_avs_waitrequest |=> !o_avs_waitrequest)
        else $error("waitrequest held longer than one cycle");
    wait_idle_a: assert property (
        !req |-> !o_avs_waitrequest)
        else $error("waitrequest high without a request");
    take_once_a: assert property (
        take |=> !take)
        else $error("two transfers completed back to back");
    hi_zero_a: assert property (
        take && i_avs_read |-> o_avs_readdata[31:8] == 24'h0)
        else $error("upper read data not zero");
    rsv_one_a: assert property (
        take && i_avs_read && i_avs_address == A_MODE
        |-> o_avs_readdata[4:3] == 2'b11)
        else $error("reserved mode bits not one");
    mode_back_a: assert property (
        take && i_avs_read && i_avs_address == A_MODE
        |-> o_avs_readdata[7:0] == mode_shadow_reg)
        else $error("mode readback wrong");
    hole_zero_a: assert property (
        take && i_avs_read && i_avs_address == A_HOLE
        |-> o_avs_readdata == 32'h0)
        else $error("unmapped read not zero");
    irq_fall_a: assert property (
        $fell(o_irq) |-> $past(take && i_avs_write))
        else $error("interrupt dropped without a write");
endmodule : arut_timer_asserts

bind arut_timer arut_timer_asserts arut_timer_asserts_inst (
    .i_core_clk(i_core_clk),
    .i_arst_n(i_arst_n),
    .i_avs_address(i_avs_address),
    .i_avs_read(i_avs_read),
    .i_avs_write(i_avs_write),
    .i_avs_writedata(i_avs_writedata),
    .i_avs_byteenable(i_avs_byteenable),
    .o_avs_readdata(o_avs_readdata),
    .o_avs_waitrequest(o_avs_waitrequest),
    .o_irq(o_irq)
);

// [dv/arut_timer_tb.sv]
// Self-checking testbench for the auto-reload up/down timer
`timescale 1ns/1ns
module arut_timer_tb;
    localparam logic [17:0] A_MODE = {arut_pkg::MODE_IDX, 2'b00};
    localparam logic [17:0] A_CNT = {arut_pkg::COUNT_IDX, 2'b00};
    localparam logic [17:0] A_IRQ = {arut_pkg::IRQ_IDX, 2'b00};
    localparam logic [17:0] A_STOP = {arut_pkg::STOP_IDX, 2'b00};
    localparam logic [17:0] A_HOLE = 18'h3fedc;
    logic i_core_clk;
    logic i_arst_n;
    logic [17:0] i_avs_address;
    logic i_avs_read;
    logic i_avs_write;
    logic [31:0] i_avs_writedata;
    logic [3:0] i_avs_byteenable;
    logic [31:0] o_avs_readdata;
    logic o_avs_waitrequest;
    logic i_event_input_pin;
    logic i_direction_pin;
    logic i_subclk_div4;
    logic i_event_edge_select;
    logic o_irq;
    int n_mismatch;
    int n_checks;
    logic [7:0] rv;

    arut_timer arut_timer_inst (
        .i_core_clk(i_core_clk),
        .i_arst_n(i_arst_n),
        .i_avs_address(i_avs_address),
        .i_avs_read(i_avs_read),
        .i_avs_write(i_avs_write),
        .i_avs_writedata(i_avs_writedata),
        .i_avs_byteenable(i_avs_byteenable),
        .o_avs_readdata(o_avs_readdata),
        .o_avs_waitrequest(o_avs_waitrequest),
        .i_event_input_pin(i_event_input_pin),
        .i_direction_pin(i_direction_pin),
        .i_subclk_div4(i_subclk_div4),
        .i_event_edge_select(i_event_edge_select),
        .o_irq(o_irq)
    );

    // 250 MHz core clock
    initial
    begin
        i_core_clk = 1'b0;
        forever #2 i_core_clk = ~i_core_clk;
    end

    // Subclock divided by four: one rising edge every 16 cycles
    initial
    begin
        i_subclk_div4 = 1'b0;
        forever
        begin
            repeat (8) @(posedge i_core_clk);
            i_subclk_div4 <= ~i_subclk_div4;
        end
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("BAD %0t got %h want %h", $time, seen, exp);
        end
    endtask : check

    // One Avalon transfer, held until waitrequest is seen low at an edge
    task automatic bus(input logic wr, input logic [17:0] a,
        input logic [7:0] d);
        i_avs_address <= a;
        i_avs_writedata <= {24'h0, d};
        i_avs_write <= wr;
        i_avs_read <= !wr;
        @(posedge i_core_clk);
        while (o_avs_waitrequest !== 1'b0)
            @(posedge i_core_clk);
        rv = o_avs_readdata[7:0];
        i_avs_write <= 1'b0;
        i_avs_read <= 1'b0;
        // One idle edge so the next call never re-drives in this step
        @(posedge i_core_clk);
    endtask : bus

    task automatic wr(input logic [17:0] a, input logic [7:0] d);
        bus(1'b1, a, d);
    endtask : wr

    task automatic rd(input logic [17:0] a);
        bus(1'b0, a, 8'h00);
    endtask : rd

    // One event pulse, long enough for the synchroniser
    task automatic pulse;
        i_event_input_pin <= 1'b1;
        repeat (6) @(posedge i_core_clk);
        i_event_input_pin <= 1'b0;
        repeat (6) @(posedge i_core_clk);
    endtask : pulse

    task automatic t_reset;
        rd(A_MODE);
        check(rv, 8'h18);
        rd(A_CNT);
        check(rv, 8'h00);
        rd(A_STOP);
        check(rv, 8'hff);
    endtask : t_reset

    task automatic t_regs;
        wr(A_MODE, 8'he7);
        rd(A_MODE);
        check(rv, 8'hff);
        // Lane 0 disabled: the write is taken but changes nothing
        i_avs_byteenable <= 4'he;
        wr(A_MODE, 8'h00);
        i_avs_byteenable <= 4'hf;
        rd(A_MODE);
        check(rv, 8'hff);
        wr(A_HOLE, 8'hff);
        rd(A_HOLE);
        check(rv, 8'h00);
        wr(A_MODE, 8'h18);
    endtask : t_regs

    // Standby halts counting but the reload write still lands
    task automatic t_standby;
        wr(A_STOP, 8'hfd);
        wr(A_MODE, 8'h05);
        wr(A_CNT, 8'h5a);
        rd(A_CNT);
        check(rv, 8'h5a);
        repeat (40) @(posedge i_core_clk);
        rd(A_CNT);
        check(rv, 8'h5a);
        wr(A_STOP, 8'hff);
    endtask : t_standby

    // Two event ticks per row: modes, directions and wraps
    task automatic t_event;
        logic [7:0] m [7] = '{8'h07, 8'h27, 8'h87, 8'ha7, 8'h67, 8'h47,
            8'h87};
        logic [7:0] r [7] = '{8'hfe, 8'h01, 8'hfe, 8'h01, 8'h10, 8'h10,
            8'hff};
        logic [7:0] e1 [7] = '{8'hff, 8'h00, 8'hff, 8'h00, 8'h11, 8'h0f,
            8'hff};
        logic [7:0] e2 [7] = '{8'h00, 8'hff, 8'hfe, 8'h01, 8'h12, 8'h0e,
            8'hff};
        logic [6:0] pin = 7'b0100000;
        logic [6:0] fl = 7'b1001111;
        // Event edge chosen and pin idle before code 111 goes in
        i_event_edge_select <= 1'b1;
        for (int i = 0; i < 7; i++)
        begin
            i_direction_pin <= pin[i];
            wr(A_MODE, m[i]);
            wr(A_CNT, r[i]);
            wr(A_IRQ, 8'h03);
            pulse();
            rd(A_CNT);
            check(rv, e1[i]);
            pulse();
            rd(A_CNT);
            check(rv, e2[i]);
            check({7'h0, o_irq}, {7'h0, fl[i]});
        end
    endtask : t_event

    // Falling edge selected: a rising edge alone must not count
    task automatic t_edge;
        i_event_edge_select <= 1'b0;
        i_direction_pin <= 1'b0;
        wr(A_MODE, 8'h07);
        wr(A_CNT, 8'h20);
        i_event_input_pin <= 1'b1;
        repeat (6) @(posedge i_core_clk);
        rd(A_CNT);
        check(rv, 8'h20);
        i_event_input_pin <= 1'b0;
        repeat (6) @(posedge i_core_clk);
        rd(A_CNT);
        check(rv, 8'h21);
    endtask : t_edge

    // Flag is left set by the last event row
    task automatic t_irq;
        wr(A_IRQ, 8'h00);
        check({7'h0, o_irq}, 8'h00);
        rd(A_IRQ);
        check(rv, 8'h01);
        wr(A_IRQ, 8'h02);
        check({7'h0, o_irq}, 8'h01);
        wr(A_IRQ, 8'h03);
        check({7'h0, o_irq}, 8'h00);
    endtask : t_irq

    // Three periods of each internal clock; bus overhead may add one
    task automatic t_ticks;
        int per [7] = '{8192, 2048, 512, 64, 16, 4, 16};
        for (int c = 0; c < 7; c++)
        begin
            wr(A_STOP, 8'hfd);
            wr(A_MODE, 8'(c));
            wr(A_CNT, 8'h00);
            wr(A_STOP, 8'hff);
            repeat (3 * per[c]) @(posedge i_core_clk);
            wr(A_STOP, 8'hfd);
            rd(A_CNT);
            check({7'h0, rv inside {8'h03, 8'h04}}, 8'h01);
        end
    endtask : t_ticks

    task automatic close_out;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : close_out

    // Main sequence
    initial
    begin
        i_arst_n = 1'b0;
        i_avs_address = 18'h0;
        i_avs_read = 1'b0;
        i_avs_write = 1'b0;
        i_avs_writedata = 32'h0;
        i_avs_byteenable = 4'hf;
        i_event_input_pin = 1'b0;
        i_direction_pin = 1'b0;
        i_event_edge_select = 1'b1;
        n_mismatch = 0;
        n_checks = 0;
        repeat (6) @(posedge i_core_clk);
        i_arst_n <= 1'b1;
        t_reset();
        t_regs();
        t_standby();
        t_event();
        t_irq();
        t_edge();
        t_ticks();
        close_out();
    end

    // Watchdog well beyond the expected 33k cycles
    initial
    begin
        #200000;
        n_mismatch++;
        close_out();
    end
endmodule : arut_timer_tb

// [src/arut_prescaler.sv]
// Free-running system clock prescaler with power-of-two tick taps
`timescale 1ns/1ns
module arut_prescaler
#(
    parameter int WIDTH = arut_pkg::PRESC_W
)
(
    input wire logic i_core_clk,
    input wire logic i_arst_n,
    output logic [arut_pkg::NUM_TAPS-1:0] o_tick
);
    logic [WIDTH-1:0] cnt_reg;
    logic [WIDTH-1:0] cnt_next;

    // Taps must fit in the counter
    if (WIDTH < arut_pkg::PRESC_W)
    begin : g_bad_width
        $error("prescaler width too small for slowest tap");
    end

    always_comb
    begin
        cnt_next = cnt_reg + {{(WIDTH-1){1'b0}}, 1'b1};
    end

    always_ff @(posedge i_core_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
            cnt_reg <= '0;
        else
            cnt_reg <= cnt_next;
    end

    // Tick when low n bits are all ones: one cycle every 2^n
    genvar g;
    generate
        for (g = 0; g < arut_pkg::NUM_TAPS; g++)
        begin : g_tap
            assign o_tick[g] = &cnt_reg[arut_pkg::TAP_BITS[g]-1:0]; // [R6]
        end
    endgenerate

endmodule : arut_prescaler

// [src/arut_sync_edge.sv]
// Two-flop synchroniser with rise and fall pulse outputs
`timescale 1ns/1ns
module arut_sync_edge
(
    input wire logic i_core_clk,
    input wire logic i_arst_n,
    input wire logic i_pin,
    output logic o_level,
    output logic o_rise,
    output logic o_fall
);
    arut_pkg::arut_sync_t st_reg;
    arut_pkg::arut_sync_t st_next;

    // Only the stable stage feeds the edge logic
    always_comb
    begin
        st_next = st_reg;
        st_next.meta = i_pin;
        st_next.stable = st_reg.meta;
        st_next.prev = st_reg.stable;
    end

    always_ff @(posedge i_core_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
            st_reg <= '0;
        else
            st_reg <= st_next;
    end

    // One pulse per settled edge
    assign o_level = st_reg.stable;
    assign o_rise = st_reg.stable & ~st_reg.prev; // [R19]
    assign o_fall = ~st_reg.stable & st_reg.prev; // [R19]

endmodule : arut_sync_edge

// [src/arut_timer.sv]
// Auto-reload up/down 8-bit timer with Avalon-MM register slave
//
// Our own choice: the Avalon-MM interface to the registers.
`timescale 1ns/1ns
module arut_timer
(
    input wire logic i_core_clk,
    input wire logic i_arst_n,
    input wire logic [arut_pkg::ADDR_W-1:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [arut_pkg::DATA_W-1:0] i_avs_writedata,
    input wire logic [3:0] i_avs_byteenable,
    output logic [arut_pkg::DATA_W-1:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    input wire logic i_event_input_pin,
    input wire logic i_direction_pin,
    input wire logic i_subclk_div4,
    input wire logic i_event_edge_select,
    output logic o_irq
);
    arut_pkg::arut_core_t st_reg;
    arut_pkg::arut_core_t st_next;

    logic [arut_pkg::NUM_TAPS-1:0] presc_tick;
    logic event_rise;
    logic event_fall;
    logic dir_level;
    logic sub_rise;
    logic count_tick;
    logic count_down;
    logic wrap;
    logic bus_req;
    logic bus_take;
    logic wr_take;
    logic wr_lane0;
    logic [7:0] wr_byte;
    logic sel_mode;
    logic sel_count;
    logic sel_irq;
    logic sel_stop;

    // Byte address of a register index
    function automatic logic hit(
        input logic [arut_pkg::ADDR_W-1:0] addr,
        input logic [15:0] idx
    );
        hit = (addr == {idx, 2'b00});
    endfunction : hit

    // Pack the mode register as software sees it
    function automatic logic [7:0] mode_byte(
        input arut_pkg::arut_mode_t m
    );
        logic [7:0] b;
        b = 8'h00;
        b[arut_pkg::MODE_RELOAD_BIT] = m.reload_mode_select;
        b[arut_pkg::MODE_DSRC_BIT] = m.direction_source_select;
        b[arut_pkg::MODE_SWDIR_BIT] = m.software_direction;
        b[arut_pkg::MODE_RSV_HI_BIT] = 1'b1; // [R5]
        b[arut_pkg::MODE_RSV_LO_BIT] = 1'b1; // [R5]
        b[arut_pkg::MODE_CLK_MSB:arut_pkg::MODE_CLK_LSB] = m.clk_sel;
        mode_byte = b;
    endfunction : mode_byte

    // Unpack a written byte into the mode fields; bits 4 and 3 dropped
    function automatic arut_pkg::arut_mode_t mode_fields(
        input logic [7:0] b
    );
        arut_pkg::arut_mode_t m;
        m.reload_mode_select = b[arut_pkg::MODE_RELOAD_BIT];
        m.direction_source_select = b[arut_pkg::MODE_DSRC_BIT];
        m.software_direction = b[arut_pkg::MODE_SWDIR_BIT];
        m.clk_sel = b[arut_pkg::MODE_CLK_MSB:arut_pkg::MODE_CLK_LSB];
        mode_fields = m;
    endfunction : mode_fields

    // Elaboration checks: the decode below hard-wires these layouts
    if (arut_pkg::NUM_TAPS != 6)
    begin : g_bad_taps
        $error("clock codes 0 to 5 need six prescaler taps");
    end

    if (arut_pkg::CLK_SUBCLK != 3'h6 || arut_pkg::CLK_EVENT != 3'h7)
    begin : g_bad_codes
        $error("only codes 0 to 5 may index the prescaler taps");
    end

    if (arut_pkg::ADDR_W != 18)
    begin : g_bad_addr
        $error("address must be a 16-bit index and two lane bits");
    end

    // Read data is a byte padded with 24 zero bits
    if (arut_pkg::DATA_W != 32)
    begin : g_bad_data
        $error("read data padding assumes a 32-bit bus");
    end

    if (arut_pkg::MODE_CLK_MSB - arut_pkg::MODE_CLK_LSB != 2)
    begin : g_bad_clk
        $error("clock select field must be three bits wide");
    end

    // Control bits are picked out of the written byte
    if (arut_pkg::STOP_TIMER_BIT > 7 || arut_pkg::IRQ_EN_BIT > 7)
    begin : g_bad_bits
        $error("control bits must lie in the low byte");
    end

    // Wrap detection compares against the full byte range
    if (arut_pkg::COUNT_MAX != 8'hff || arut_pkg::COUNT_MIN != 8'h00)
    begin : g_bad_range
        $error("count limits must span the whole byte");
    end

    // System clock prescaler taps
    arut_prescaler #(
        .WIDTH(arut_pkg::PRESC_W)
    ) u_presc (
        .i_core_clk(i_core_clk),
        .i_arst_n(i_arst_n),
        .o_tick(presc_tick)
    );

    // External event pin
    arut_sync_edge u_sync_event (
        .i_core_clk(i_core_clk),
        .i_arst_n(i_arst_n),
        .i_pin(i_event_input_pin),
        .o_level(),
        .o_rise(event_rise),
        .o_fall(event_fall)
    );

    // External direction pin
    arut_sync_edge u_sync_dir (
        .i_core_clk(i_core_clk),
        .i_arst_n(i_arst_n),
        .i_pin(i_direction_pin),
        .o_level(dir_level),
        .o_rise(),
        .o_fall()
    );

    // Subclock quarter rate; asynchronous, so costs up to one cycle jitter
    arut_sync_edge u_sync_sub (
        .i_core_clk(i_core_clk),
        .i_arst_n(i_arst_n),
        .i_pin(i_subclk_div4),
        .o_level(),
        .o_rise(sub_rise),
        .o_fall()
    );

    // Count clock selection, gated by module standby
    always_comb
    begin
        case (st_reg.mode.clk_sel)
            arut_pkg::CLK_SUBCLK:
                count_tick = sub_rise; // [R6] [R19]
            arut_pkg::CLK_EVENT:
                // [R7] [R19]
                count_tick = i_event_edge_select ? event_rise : event_fall;
            default:
                count_tick = presc_tick[st_reg.mode.clk_sel]; // [R6]
        endcase
        // Standby stops ticks only; bus writes still land
        if (!st_reg.module_clock_stop[arut_pkg::STOP_TIMER_BIT])
            count_tick = 1'b0; // [R18]
    end

    // Direction: pin high means down when hardware-steered
    always_comb
    begin
        if (st_reg.mode.direction_source_select)
            count_down = dir_level; // [R4]
        else
            count_down = st_reg.mode.software_direction; // [R3]
    end

    // Wrap past the end of the range in the current direction
    assign wrap = count_tick & (count_down ?
        (st_reg.count_value == arut_pkg::COUNT_MIN) :
        (st_reg.count_value == arut_pkg::COUNT_MAX)); // [R10]

    // Bus request; answer comes one cycle after the request appears
    assign bus_req = i_avs_read | i_avs_write;
    assign bus_take = bus_req & (st_reg.phase == arut_pkg::PH_ANSWER);

    // Writes act on lane 0 only, at the take edge
    assign wr_take = bus_take & i_avs_write;
    assign wr_lane0 = wr_take & i_avs_byteenable[0];
    assign wr_byte = i_avs_writedata[7:0];

    // Register select, decoded once for the read and write paths
    assign sel_mode = hit(i_avs_address, arut_pkg::MODE_IDX);
    assign sel_count = hit(i_avs_address, arut_pkg::COUNT_IDX); // [R11]
    assign sel_irq = hit(i_avs_address, arut_pkg::IRQ_IDX);
    assign sel_stop = hit(i_avs_address, arut_pkg::STOP_IDX);

    // Next state of the whole core
    always_comb
    begin
        st_next = st_reg;

        // Bus phase
        case (st_reg.phase)
            arut_pkg::PH_IDLE:
            begin
                if (bus_req)
                    st_next.phase = arut_pkg::PH_ANSWER;
            end
            arut_pkg::PH_ANSWER:
                st_next.phase = arut_pkg::PH_IDLE;
            default:
                st_next.phase = arut_pkg::PH_IDLE;
        endcase

        // Read data captured one cycle ahead so it stands at the take edge
        if (st_reg.phase == arut_pkg::PH_IDLE && i_avs_read)
        begin
            if (sel_mode)
                st_next.rdata = mode_byte(st_reg.mode); // [R5]
            else if (sel_count)
                st_next.rdata = st_reg.count_value; // [R9] [R11]
            else if (sel_irq)
                st_next.rdata = {6'h00, st_reg.timer_irq_enable,
                                 st_reg.timer_irq_flag};
            else if (sel_stop)
                st_next.rdata = st_reg.module_clock_stop;
            else
                st_next.rdata = 8'h00;
        end

        // Counting: wrap target depends on mode
        if (count_tick)
        begin
            if (wrap)
            begin
                if (st_reg.mode.reload_mode_select)
                    st_next.count_value = st_reg.reload_value; // [R2] [R14]
                else if (count_down)
                    st_next.count_value = arut_pkg::COUNT_MAX; // [R2] [R16]
                else
                    st_next.count_value = arut_pkg::COUNT_MIN; // [R2] [R16]
            end
            else if (count_down)
                st_next.count_value = st_reg.count_value - 8'h01;
            else
                st_next.count_value = st_reg.count_value + 8'h01;
        end

        // Register writes on lane 0; a reload write beats a count tick
        if (wr_lane0)
        begin
            if (sel_mode)
                st_next.mode = mode_fields(wr_byte); // [R5]
            else if (sel_count)
            begin
                st_next.reload_value = wr_byte; // [R11] [R15]
                st_next.count_value = wr_byte; // [R13]
            end
            else if (sel_irq)
            begin
                st_next.timer_irq_enable = wr_byte[arut_pkg::IRQ_EN_BIT];
                if (wr_byte[arut_pkg::IRQ_FLAG_BIT])
                    st_next.timer_irq_flag = 1'b0;
            end
            else if (sel_stop)
                st_next.module_clock_stop = wr_byte; // [R18]
        end

        // Setting wins over a simultaneous software clear
        if (wrap)
            st_next.timer_irq_flag = 1'b1; // [R10]
    end

    // State register; reset gives interval, up, slowest clock
    always_ff @(posedge i_core_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            st_reg.phase <= arut_pkg::PH_IDLE;
            st_reg.mode <= mode_fields(arut_pkg::MODE_RESET); // [R1]
            st_reg.count_value <= arut_pkg::COUNT_RESET; // [R12]
            st_reg.reload_value <= arut_pkg::RELOAD_RESET; // [R15]
            st_reg.module_clock_stop <= arut_pkg::STOP_RESET; // [R18]
            st_reg.timer_irq_flag <= 1'b0;
            st_reg.timer_irq_enable <= 1'b0;
            st_reg.rdata <= 8'h00;
        end
        else
            st_reg <= st_next;
    end

    // Waitrequest is combinational: one wait state per request
    assign o_avs_waitrequest = bus_req &
        (st_reg.phase != arut_pkg::PH_ANSWER);

    // Read data from a flop so it stands through the answer cycle
    assign o_avs_readdata = {24'h000000, st_reg.rdata};

    // Interrupt only while both flag and enable stand
    assign o_irq = st_reg.timer_irq_flag & st_reg.timer_irq_enable; // [R17]

endmodule : arut_timer
